// ---- rtl/sci_map.vh ----
// Constants for the sensor command interpreter: offsets, resets, limits, codes
`ifndef SCI_MAP_VH
`define SCI_MAP_VH
`define SCI_REG_STATUS 4'h0
`define SCI_REG_ADDR 4'h1
`define SCI_REG_MEAS 4'h2
`define SCI_REG_NORTH 4'h3
`define SCI_REG_OUTINT 4'h4
`define SCI_REG_AVG 4'h5
`define SCI_REG_CTRL 4'h6
`define SCI_CTRL_DISTURB_BIT 0
`define SCI_RST_HELP 2'h0
`define SCI_RST_POWER 4'h0
`define SCI_RST_MODE 3'h1
`define SCI_RST_ADDR 7'h00
`define SCI_RST_MEAS 15'h0002
`define SCI_RST_NORTH 9'h000
`define SCI_RST_OUTINT 14'h0064
`define SCI_RST_AVG 11'h00a
`define SCI_MAX_HELP 17'h00002
`define SCI_MAX_MODE 17'h00005
`define SCI_MAX_ADDR 17'h00063
`define SCI_MAX_MEAS 17'h07530
`define SCI_MAX_NORTH 17'h00167
`define SCI_MIN_OUTINT 17'h0000a
`define SCI_MAX_OUTINT 17'h02710
`define SCI_MAX_AVG 17'h004b0
`define SCI_WILD_ADDR 7'h63
`define SCI_KEY_QUERY 17'h00000
`define SCI_KEY_USER 17'h00001
`define SCI_KEY_CONFIG 17'h01267
`define SCI_LVL_QUERY 2'h0
`define SCI_LVL_USER 2'h1
`define SCI_LVL_CONFIG 2'h2
`define SCI_CMD_HELP 16'h4848
`define SCI_CMD_POWER 16'h4850
`define SCI_CMD_MODE 16'h4854
`define SCI_CMD_ADDR 16'h4944
`define SCI_CMD_KEY 16'h4b59
`define SCI_CMD_MEAS 16'h4d44
`define SCI_CMD_AVG 16'h4156
`define SCI_CMD_NORTH 16'h4e43
`define SCI_CMD_OUTINT 16'h4f52
`define SCI_CH_CR 8'h0d
`define SCI_CH_BANG 8'h21
`define SCI_CH_ZERO 8'h30
`define SCI_CLK_HZ 25000000
`define SCI_TICK_MS 1
`define SCI_MEAS_UNIT_MS 10
`define SCI_AVG_UNIT_MS 17'h00064
`endif

// ---- rtl/sci_top.v ----
// Sensor command interpreter: command parser, access levels, settings, timers
`include "sci_map.vh"

// Functional notes
// - Help 0: verbose text, bootloader first
// - Help 1: echo-only answers with exclamation
// - Help 2: silent boot; above 2 rejected
// - Power 0..4, 10..13; high transducer-on-disturb
// - Power applies only while heating enabled
// - Mode 3/4: control line high/low disables
// - Mode 5: line low 120W, high 240W
// - Act on own address 0..99, immediately
// - Address 99 always answered
// - Ack: bang, address, letters, five digits
// - Key 0 query, 1 user, 4711 config
// - Query level changes no stored parameter
// - Lowering level saves to nonvolatile store
// - Restart enters query level
// - Measure interval 10 ms units, 0..30000
// - North offset 0..359 added to direction
// - Telegram interval 10..10000 ms, reset 100
// - Interval 0: telegram on line trigger
// - Due while sending: discard, no queue
// - Faster than measurement: repeat values
// - Averaging 0: use output interval
module sci_top #(
    parameter MS_CYCLES = `SCI_CLK_HZ / 1000 * `SCI_TICK_MS
) (
    input wire clk, // 25 MHz system clock
    input wire rst_n, // Asynchronous reset, active low
    input wire [7:0] rx_data, // Received character
    input wire rx_valid, // Character strobe
    output reg [7:0] tx_data_ff, // Answer character
    output reg tx_valid_ff, // Answer character valid
    input wire tx_ready, // Transmitter takes character
    input wire ctrl_line, // External control line pin
    input wire heat_demand, // Thermostat calls for heat
    input wire meas_done, // Measurement completed pulse
    input wire tele_busy, // Telegram still being sent
    input wire [3:0] reg_addr, // Register address
    input wire [15:0] reg_wdata, // Register write data
    input wire reg_wr, // Register write strobe
    input wire reg_rd, // Register read strobe
    output reg [15:0] reg_rdata_ff, // Register read data
    output reg verbose_ff, // Full text messages on
    output reg boot_loader_first_ff, // Bootloader runs before main
    output reg silent_boot_ff, // No restart messages
    output reg heat_on_ff, // Heating active
    output reg heat_hot_setpoint_ff, // Test setpoint selected
    output reg [2:0] heat_level_ff, // Power selection 0..4
    output reg xdcr_heat_ff, // Transducer heating on
    output reg [1:0] level_ff, // Granted access level
    output reg nv_save_ff, // Save parameters pulse
    output reg [8:0] north_ff, // Direction offset degrees
    output reg meas_start_ff, // Start measuring cycle pulse
    output reg tele_start_ff, // Start telegram pulse
    output reg tele_repeat_ff, // Telegram repeats old values
    output reg [16:0] avg_ms_ff // Effective averaging period ms
);

    reg [7:0] buf_ff [0:8];
    reg [3:0] cnt_ff;
    reg [3:0] eval_cnt_ff;
    reg eval_ff;
    reg [1:0] help_ff;
    reg [3:0] power_ff;
    reg [2:0] mode_ff;
    reg [6:0] addr_ff;
    reg [14:0] meas_ff;
    reg [13:0] outint_ff;
    reg [10:0] avg_ff;
    reg disturb_ff;
    reg ctl_s1_ff;
    reg ctl_s2_ff;
    reg ctl_prev_ff;
    reg [7:0] rsp_ch_ff [0:3];
    reg [16:0] rsp_val_ff;
    reg [3:0] tx_idx_ff;
    reg tx_act_ff;
    reg [15:0] ms_cnt_ff;
    reg ms_tick_ff;
    reg [13:0] tele_cnt_ff;
    reg [3:0] ten_cnt_ff;
    reg [14:0] meas_cnt_ff;
    reg fresh_ff;
    integer i;

    function is_dig;
        input [7:0] c;
        begin
            is_dig = (c >= 8'h30) && (c <= 8'h39);
        end
    endfunction

    function [3:0] dig;
        input [7:0] c;
        begin
            dig = c[3:0];
        end
    endfunction

    // Decimal digit of the answer value, position 0 is most significant
    function [7:0] dec_ch;
        input [16:0] v;
        input [2:0] pos;
        reg [16:0] q;
        begin
            case (pos)
                3'h0: q = v / 17'd10000;
                3'h1: q = v / 17'd1000;
                3'h2: q = v / 17'd100;
                3'h3: q = v / 17'd10;
                default: q = v;
            endcase
            q = q % 17'd10;
            dec_ch = `SCI_CH_ZERO + {4'h0, q[3:0]};
        end
    endfunction

    // Parsed fields
    wire [6:0] cmd_addr = {3'h0, dig(buf_ff[0])} * 7'd10 + {3'h0, dig(buf_ff[1])};
    wire [16:0] cmd_par = {13'h0, dig(buf_ff[4])} * 17'd10000
        + {13'h0, dig(buf_ff[5])} * 17'd1000 + {13'h0, dig(buf_ff[6])} * 17'd100
        + {13'h0, dig(buf_ff[7])} * 17'd10 + {13'h0, dig(buf_ff[8])};
    wire [15:0] cmd_code = {buf_ff[2], buf_ff[3]};
    wire has_par = (eval_cnt_ff == 4'h9);
    wire par_digits = is_dig(buf_ff[4]) && is_dig(buf_ff[5]) && is_dig(buf_ff[6])
        && is_dig(buf_ff[7]) && is_dig(buf_ff[8]);
    wire form_ok = is_dig(buf_ff[0]) && is_dig(buf_ff[1])
        && ((eval_cnt_ff == 4'h4) || (has_par && par_digits));
    wire addr_hit = (cmd_addr == addr_ff) || (cmd_addr == `SCI_WILD_ADDR);

    reg [1:0] req_lvl;
    reg [16:0] cur_val;
    reg known;
    reg range_ok;
    reg [1:0] key_lvl;

    always @* begin
        req_lvl = `SCI_LVL_CONFIG;
        cur_val = 17'h0;
        known = 1'b1;
        range_ok = 1'b0;
        key_lvl = `SCI_LVL_QUERY;
        case (cmd_code)
            `SCI_CMD_HELP: begin
                cur_val = {15'h0, help_ff};
                range_ok = cmd_par <= `SCI_MAX_HELP;
            end
            `SCI_CMD_POWER: begin
                cur_val = {13'h0, power_ff};
                range_ok = (cmd_par <= 17'd4) || ((cmd_par >= 17'd10) && (cmd_par <= 17'd13));
            end
            `SCI_CMD_MODE: begin
                cur_val = {14'h0, mode_ff};
                range_ok = cmd_par <= `SCI_MAX_MODE;
            end
            `SCI_CMD_ADDR: begin
                cur_val = {10'h0, addr_ff};
                range_ok = cmd_par <= `SCI_MAX_ADDR;
            end
            `SCI_CMD_KEY: begin
                req_lvl = `SCI_LVL_QUERY;
                cur_val = {15'h0, level_ff};
                range_ok = 1'b1;
                if (cmd_par == `SCI_KEY_USER) begin
                    key_lvl = `SCI_LVL_USER;
                end else if (cmd_par == `SCI_KEY_CONFIG) begin
                    key_lvl = `SCI_LVL_CONFIG;
                end else if (cmd_par != `SCI_KEY_QUERY) begin
                    range_ok = 1'b0;
                end
            end
            `SCI_CMD_MEAS: begin
                cur_val = {2'h0, meas_ff};
                range_ok = cmd_par <= `SCI_MAX_MEAS;
            end
            `SCI_CMD_AVG: begin
                req_lvl = `SCI_LVL_USER;
                cur_val = {6'h0, avg_ff};
                range_ok = cmd_par <= `SCI_MAX_AVG;
            end
            `SCI_CMD_NORTH: begin
                cur_val = {8'h0, north_ff};
                range_ok = cmd_par <= `SCI_MAX_NORTH;
            end
            `SCI_CMD_OUTINT: begin
                cur_val = {3'h0, outint_ff};
                range_ok = (cmd_par == 17'h0) || ((cmd_par >= `SCI_MIN_OUTINT)
                    && (cmd_par <= `SCI_MAX_OUTINT));
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end

    wire do_cmd = eval_ff && !tx_act_ff && form_ok && addr_hit && known;
    // Query level cannot reach any stored setting since all need user or config
    wire do_set = do_cmd && has_par && range_ok && (level_ff >= req_lvl);
    wire do_ans = do_cmd && (!has_par || do_set);

    // Collects characters; the terminator hands the line over for decoding
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 4'h0;
            eval_cnt_ff <= 4'h0;
            eval_ff <= 1'b0;
            for (i = 0; i < 9; i = i + 1) begin
                buf_ff[i] <= 8'h00;
            end
        end else begin
            eval_ff <= 1'b0;
            if (rx_valid) begin
                if (rx_data == `SCI_CH_CR) begin
                    eval_ff <= 1'b1;
                    eval_cnt_ff <= cnt_ff;
                    cnt_ff <= 4'h0;
                end else if (cnt_ff < 4'h9) begin
                    buf_ff[cnt_ff] <= rx_data;
                    cnt_ff <= cnt_ff + 4'h1;
                end else begin
                    cnt_ff <= 4'ha; // Overlong line is dropped
                end
            end
        end
    end

    // Settings, access level and save request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            help_ff <= `SCI_RST_HELP;
            power_ff <= `SCI_RST_POWER;
            mode_ff <= `SCI_RST_MODE;
            addr_ff <= `SCI_RST_ADDR;
            meas_ff <= `SCI_RST_MEAS;
            north_ff <= `SCI_RST_NORTH;
            outint_ff <= `SCI_RST_OUTINT;
            avg_ff <= `SCI_RST_AVG;
            level_ff <= `SCI_LVL_QUERY;
            nv_save_ff <= 1'b0;
        end else begin
            nv_save_ff <= 1'b0;
            if (do_set) begin
                case (cmd_code)
                    `SCI_CMD_HELP: help_ff <= cmd_par[1:0];
                    `SCI_CMD_POWER: power_ff <= cmd_par[3:0];
                    `SCI_CMD_MODE: mode_ff <= cmd_par[2:0];
                    `SCI_CMD_ADDR: addr_ff <= cmd_par[6:0];
                    `SCI_CMD_MEAS: meas_ff <= cmd_par[14:0];
                    `SCI_CMD_AVG: avg_ff <= cmd_par[10:0];
                    `SCI_CMD_NORTH: north_ff <= cmd_par[8:0];
                    `SCI_CMD_OUTINT: outint_ff <= cmd_par[13:0];
                    `SCI_CMD_KEY: begin
                        level_ff <= key_lvl;
                        nv_save_ff <= key_lvl < level_ff;
                    end
                    default: level_ff <= level_ff;
                endcase
            end
        end
    end

    // Answer: bang, echoed address and letters, five digits, terminator
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_act_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            tx_idx_ff <= 4'h0;
            rsp_val_ff <= 17'h0;
            for (i = 0; i < 4; i = i + 1) begin
                rsp_ch_ff[i] <= 8'h00;
            end
        end else if (do_ans) begin
            tx_act_ff <= 1'b1;
            tx_valid_ff <= 1'b1;
            tx_data_ff <= `SCI_CH_BANG;
            tx_idx_ff <= 4'h1;
            rsp_val_ff <= has_par ? cmd_par : cur_val;
            for (i = 0; i < 4; i = i + 1) begin
                rsp_ch_ff[i] <= buf_ff[i];
            end
        end else if (tx_act_ff && tx_ready) begin
            tx_idx_ff <= tx_idx_ff + 4'h1;
            if (tx_idx_ff <= 4'h4) begin
                tx_data_ff <= rsp_ch_ff[tx_idx_ff[1:0] - 2'h1];
            end else if (tx_idx_ff <= 4'h9) begin
                tx_data_ff <= dec_ch(rsp_val_ff, tx_idx_ff[2:0] - 3'h5);
            end else if (tx_idx_ff == 4'ha) begin
                tx_data_ff <= `SCI_CH_CR;
            end else begin
                tx_act_ff <= 1'b0;
                tx_valid_ff <= 1'b0;
            end
        end
    end

    // Boot and message style follow the help setting
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            verbose_ff <= 1'b1;
            boot_loader_first_ff <= 1'b1;
            silent_boot_ff <= 1'b0;
        end else begin
            verbose_ff <= help_ff == 2'h0;
            boot_loader_first_ff <= help_ff == 2'h0;
            silent_boot_ff <= help_ff == 2'h2;
        end
    end

    // Control line synchroniser and edge memory
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_s1_ff <= 1'b0;
            ctl_s2_ff <= 1'b0;
            ctl_prev_ff <= 1'b0;
        end else begin
            ctl_s1_ff <= ctrl_line;
            ctl_s2_ff <= ctl_s1_ff;
            ctl_prev_ff <= ctl_s2_ff;
        end
    end

    reg heat_en;
    always @* begin
        case (mode_ff)
            3'h1, 3'h2, 3'h5: heat_en = 1'b1;
            3'h3: heat_en = !ctl_s2_ff;
            3'h4: heat_en = ctl_s2_ff;
            default: heat_en = 1'b0;
        endcase
    end

    // Heater: selector matters only while heating is enabled
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heat_on_ff <= 1'b0;
            heat_hot_setpoint_ff <= 1'b0;
            heat_level_ff <= 3'h0;
            xdcr_heat_ff <= 1'b0;
        end else begin
            heat_hot_setpoint_ff <= mode_ff == 3'h2;
            heat_on_ff <= heat_en && heat_demand;
            if (!(heat_en && heat_demand)) begin
                heat_level_ff <= 3'h0;
                xdcr_heat_ff <= 1'b0;
            end else if (mode_ff == 3'h5) begin
                heat_level_ff <= ctl_s2_ff ? 3'h0 : 3'h1;
                xdcr_heat_ff <= 1'b1;
            end else begin
                heat_level_ff <= (power_ff == 4'h4) ? 3'h4 : power_ff[2:0] - {power_ff[3], 1'b0};
                xdcr_heat_ff <= (power_ff < 4'ha) || disturb_ff;
            end
        end
    end

    // Millisecond tick; the divider count is a parameter so tests can shorten it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_ff <= 16'h0;
            ms_tick_ff <= 1'b0;
        end else begin
            ms_tick_ff <= 1'b0;
            if (ms_cnt_ff >= MS_CYCLES[15:0] - 16'h1) begin
                ms_cnt_ff <= 16'h0;
                ms_tick_ff <= 1'b1;
            end else begin
                ms_cnt_ff <= ms_cnt_ff + 16'h1;
            end
        end
    end

    // Measuring cycle starts every interval of 10 ms steps
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ten_cnt_ff <= 4'h0;
            meas_cnt_ff <= 15'h0;
            meas_start_ff <= 1'b0;
        end else begin
            meas_start_ff <= 1'b0;
            if (ms_tick_ff) begin
                if (ten_cnt_ff == `SCI_MEAS_UNIT_MS - 1) begin
                    ten_cnt_ff <= 4'h0;
                    if (meas_cnt_ff + 15'h1 >= meas_ff) begin
                        meas_cnt_ff <= 15'h0;
                        meas_start_ff <= 1'b1;
                    end else begin
                        meas_cnt_ff <= meas_cnt_ff + 15'h1;
                    end
                end else begin
                    ten_cnt_ff <= ten_cnt_ff + 4'h1;
                end
            end
        end
    end

    wire tele_due = (outint_ff == 14'h0) ? (ctl_s2_ff && !ctl_prev_ff)
        : (ms_tick_ff && (tele_cnt_ff + 14'h1 >= outint_ff));

    // Telegram pacing; a due slot while the last one still runs is lost
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tele_cnt_ff <= 14'h0;
            tele_start_ff <= 1'b0;
            tele_repeat_ff <= 1'b0;
            fresh_ff <= 1'b0;
        end else begin
            tele_start_ff <= 1'b0;
            if (ms_tick_ff) begin
                tele_cnt_ff <= tele_due ? 14'h0 : tele_cnt_ff + 14'h1;
            end
            if (tele_due && !tele_busy) begin
                tele_start_ff <= 1'b1;
                tele_repeat_ff <= !fresh_ff;
                fresh_ff <= meas_done;
            end else if (meas_done) begin
                fresh_ff <= 1'b1;
            end
        end
    end

    // Averaging period falls back to the output interval when zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avg_ms_ff <= 17'h0;
        end else if (avg_ff == 11'h0) begin
            avg_ms_ff <= {3'h0, outint_ff};
        end else begin
            avg_ms_ff <= {6'h0, avg_ff} * `SCI_AVG_UNIT_MS;
        end
    end

    // Register port: read data appear the cycle after the read strobe only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 16'h0;
            disturb_ff <= 1'b0;
        end else begin
            if (reg_wr && (reg_addr == `SCI_REG_CTRL)) begin
                disturb_ff <= reg_wdata[`SCI_CTRL_DISTURB_BIT];
            end
            reg_rdata_ff <= 16'h0;
            if (reg_rd) begin
                case (reg_addr)
                    `SCI_REG_STATUS: reg_rdata_ff <= {5'h0, level_ff, help_ff, mode_ff, power_ff};
                    `SCI_REG_ADDR: reg_rdata_ff <= {9'h0, addr_ff};
                    `SCI_REG_MEAS: reg_rdata_ff <= {1'h0, meas_ff};
                    `SCI_REG_NORTH: reg_rdata_ff <= {7'h0, north_ff};
                    `SCI_REG_OUTINT: reg_rdata_ff <= {2'h0, outint_ff};
                    `SCI_REG_AVG: reg_rdata_ff <= {5'h0, avg_ff};
                    `SCI_REG_CTRL: reg_rdata_ff <= {15'h0, disturb_ff};
                    default: reg_rdata_ff <= 16'h0;
                endcase
            end
        end
    end

endmodule // sci_top

// ---- bench/sci_host.sv ----
// Host model on the command line: sends command lines, collects answers
`include "sci_map.vh"
module sci_host (
    input wire clk, // System clock
    input wire [7:0] tx_data_ff, // Answer character
    input wire tx_valid_ff, // Answer character valid
    output logic [7:0] rx_data, // Command character
    output logic rx_valid, // Character strobe
    output logic tx_ready // Host takes the answer character
);
    timeunit 1ns;
    timeprecision 1ps;
    bit slow = 1'b0;
    string reply = "";
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    // A slow host takes every second cycle only
    always @(posedge clk) begin
        if (tx_valid_ff && tx_ready)
            reply = {reply, string'(tx_data_ff)};
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // Lines end with carriage return
    task automatic send(input string l);
        reply = "";
        for (int i = 0; i <= l.len(); i++) begin
            @(posedge clk);
            rx_data <= (i == l.len()) ? `SCI_CH_CR : l[i];
            rx_valid <= 1'b1;
            @(posedge clk);
            rx_valid <= 1'b0;
            // Scrambled idle exposes stale reads
            rx_data <= ~rx_data;
        end
        repeat (40) @(posedge clk);
    endtask
endmodule // sci_host

// ---- bench/sci_top_monitor.sv ----
// Port checker for the sensor command interpreter
`include "sci_map.vh"
module sci_top_monitor (
    input wire clk, // System clock
    input wire rst_n, // Reset, active low
    input wire [7:0] rx_data, // Received character
    input wire rx_valid, // Character strobe
    input wire [7:0] tx_data_ff, // Answer character
    input wire tx_valid_ff, // Answer valid
    input wire tx_ready, // Host takes answer
    input wire tele_busy, // Telegram in progress
    input wire verbose_ff, // Full text on
    input wire boot_loader_first_ff, // Bootloader first
    input wire silent_boot_ff, // Silent restart
    input wire heat_on_ff, // Heating active
    input wire [2:0] heat_level_ff, // Power selection
    input wire [1:0] level_ff, // Access level
    input wire nv_save_ff, // Save pulse
    input wire tele_start_ff // Telegram pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire cr_seen = rx_valid && (rx_data == `SCI_CH_CR);
    chk_help_pair: assert property (verbose_ff == boot_loader_first_ff)
        else $error("verbose and bootloader flags differ");
    chk_help_silent: assert property (!(verbose_ff && silent_boot_ff))
        else $error("verbose and silent boot both on");
    chk_level_legal: assert property (level_ff != 2'h3)
        else $error("access level out of range");
    chk_save_on_drop: assert property (level_ff < $past(level_ff) |-> nv_save_ff)
        else $error("level lowered without save pulse");
    chk_heat_off_idle: assert property (!heat_on_ff |-> heat_level_ff == 3'h0)
        else $error("power selection while heating off");
    chk_busy_no_tele: assert property (
        $past(tele_busy) && tele_busy |-> !tele_start_ff)
        else $error("telegram started while busy");
    chk_tx_hold: assert property (
        tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
        else $error("answer character dropped before taken");
    chk_ack_bang: assert property (
        $rose(tx_valid_ff) |-> tx_data_ff == `SCI_CH_BANG)
        else $error("answer does not start with bang");
    chk_ack_delay: assert property ($rose(tx_valid_ff) |-> $past(cr_seen, 2))
        else $error("answer not two cycles after line end");
    chk_restart_query: assert property (
        $rose(rst_n) |-> level_ff == `SCI_LVL_QUERY)
        else $error("restart not at query level");
    cover property (nv_save_ff);
    cover property ($rose(tx_valid_ff));
    cover property (heat_on_ff && heat_level_ff == 3'h1);
endmodule // sci_top_monitor

// ---- bench/tb_top.sv ----
// Testbench for the sensor command interpreter
`include "sci_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ctrl_line = 0, heat_demand = 1;
    logic meas_done = 0, tele_busy = 0, nv_seen = 0, trep = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    wire [7:0] rx_data, tx_data_ff;
    wire [15:0] reg_rdata_ff;
    wire [2:0] heat_level_ff;
    wire [1:0] level_ff;
    wire [8:0] north_ff;
    wire [16:0] avg_ms_ff;
    wire rx_valid, tx_ready, tx_valid_ff, verbose_ff, boot_loader_first_ff, silent_boot_ff;
    wire heat_on_ff, xdcr_heat_ff, nv_save_ff, meas_start_ff, tele_start_ff, tele_repeat_ff;
    int fail_count = 0, comparisons = 0, mcnt = 0, mgap = 0, tcnt = 0, tgap = 0, tnum = 0, n;
    sci_top #(.MS_CYCLES(4)) sci_top_i (.clk, .rst_n, .rx_data, .rx_valid, .tx_data_ff,
        .tx_valid_ff, .tx_ready, .ctrl_line, .heat_demand, .meas_done, .tele_busy, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .verbose_ff, .boot_loader_first_ff,
        .silent_boot_ff, .heat_on_ff, .heat_hot_setpoint_ff(), .heat_level_ff, .xdcr_heat_ff,
        .level_ff, .nv_save_ff, .north_ff, .meas_start_ff, .tele_start_ff, .tele_repeat_ff,
        .avg_ms_ff);
    sci_host host_i (.clk, .tx_data_ff, .tx_valid_ff, .rx_data, .rx_valid, .tx_ready);
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        mcnt <= meas_start_ff ? 1 : mcnt + 1;
        if (meas_start_ff) mgap <= mcnt;
        tcnt <= tele_start_ff ? 1 : tcnt + 1;
        if (tele_start_ff) begin
            tgap <= tcnt;
            tnum <= tnum + 1;
            trep <= tele_repeat_ff;
        end
        if (nv_save_ff) nv_seen <= 1'b1;
    end
    task automatic stop_test;
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask
    task automatic cmd(input string l, input bit ok);
        string e;
        e = ok ? {"!", l, "\r"} : "";
        host_i.send(l);
        comparisons++;
        if (host_i.reply != e) begin
            fail_count++;
            $display("BAD reply to %s exp %s got %s", l, e, host_i.reply);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata_ff);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("verbose", 1, verbose_ff);
        chk("avg ms", 1000, avg_ms_ff);
        rd(`SCI_REG_OUTINT, 100, "outint");
        rd(4'hf, 0, "unmapped");
        wr(`SCI_REG_ADDR, 16'h0005);
        rd(`SCI_REG_ADDR, 0, "addr");
        repeat (900) @(posedge clk);
        chk("meas gap", 80, mgap);
        chk("tele gap", 400, tgap);
        chk("repeat", 1, trep);
        meas_done <= 1'b1;
        @(posedge clk);
        meas_done <= 1'b0;
        repeat (410) @(posedge clk);
        chk("fresh", 0, trep);
        cmd("00NC00045", 0);
        cmd("00KY00002", 0);
        host_i.slow = 1'b1;
        cmd("00KY04711", 1);
        host_i.slow = 1'b0;
        chk("level", `SCI_LVL_CONFIG, level_ff);
        cmd("00NC00360", 0);
        cmd("00HH00003", 0);
        for (int i = 2; i >= 0; i--) begin
            cmd($sformatf("00HH%05d", i), 1);
            chk("verbose", i == 0, verbose_ff);
            chk("silent", i == 2, silent_boot_ff);
        end
        cmd("00ID00023", 1);
        cmd("00NC00010", 0);
        cmd("23NC00010", 1);
        cmd("99NC00011", 1);
        chk("north", 11, north_ff);
        cmd("23ID00000", 1);
        cmd("00AV00000", 1);
        chk("avg ms", 100, avg_ms_ff);
        cmd("00MD00000", 1);
        repeat (200) @(posedge clk);
        chk("meas gap", 40, mgap);
        cmd("00HP00005", 0);
        cmd("00HP00004", 1);
        chk("heat level", 4, heat_level_ff);
        cmd("00HT00000", 1);
        chk("heat on", 0, heat_on_ff);
        for (int m = 3; m <= 4; m++) begin
            cmd($sformatf("00HT%05d", m), 1);
            for (int v = 0; v <= 1; v++) begin
                ctrl_line <= v[0];
                repeat (8) @(posedge clk);
                chk("heat on", v[0] ^ (m == 3), heat_on_ff);
            end
        end
        cmd("00HP00000", 1);
        cmd("00HT00005", 1);
        for (int v = 0; v <= 1; v++) begin
            ctrl_line <= v[0];
            repeat (8) @(posedge clk);
            chk("heat level", !v[0], heat_level_ff);
        end
        cmd("00HP00011", 1);
        cmd("00HT00001", 1);
        chk("heat level", 1, heat_level_ff);
        for (int v = 0; v <= 1; v++) begin
            wr(`SCI_REG_CTRL, 16'(v));
            chk("xdcr", v, xdcr_heat_ff);
        end
        ctrl_line <= 1'b0;
        cmd("00OR00000", 1);
        n = tnum;
        ctrl_line <= 1'b1;
        repeat (8) @(posedge clk);
        chk("trigger", n + 1, tnum);
        cmd("00OR00010", 1);
        tele_busy <= 1'b1;
        repeat (2) @(posedge clk);
        n = tnum;
        repeat (200) @(posedge clk);
        chk("busy drop", n, tnum);
        tele_busy <= 1'b0;
        cmd("00KY00000", 1);
        chk("save", 1, nv_seen);
        cmd("00KY04711", 1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk("level", `SCI_LVL_QUERY, level_ff);
        stop_test;
    end
endmodule // tb_top
bind sci_top sci_top_monitor sci_top_monitor_i (.clk, .rst_n, .rx_data, .rx_valid, .tx_data_ff,
    .tx_valid_ff, .tx_ready, .tele_busy, .verbose_ff, .boot_loader_first_ff, .silent_boot_ff,
    .heat_on_ff, .heat_level_ff, .level_ff, .nv_save_ff, .tele_start_ff);
